// >>> sensor_seq_pkg.sv
// shared constants and types of the measurement sequencer
`default_nettype none
package sensor_seq_pkg;
  // timebase
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned NVM_WRITE_TIME_MS = 77;
  localparam int unsigned RATE_COUNT = 5;
  // register byte offsets
  localparam logic [5:0] OFS_CMD = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_RES_T = 6'h08;
  localparam logic [5:0] OFS_RES_H = 6'h0c;
  localparam logic [5:0] OFS_CFG = 6'h10;
  localparam logic [5:0] OFS_MM_T = 6'h14;
  localparam logic [5:0] OFS_MM_H = 6'h18;
  localparam logic [5:0] OFS_THR = 6'h1c;
  localparam logic [5:0] OFS_THR_LAST = 6'h28;
  // command word fields
  localparam int unsigned CMD_CODE_LSB = 0;
  localparam int unsigned CMD_CODE_W = 4;
  localparam int unsigned CMD_CT_LSB = 4;
  localparam int unsigned CMD_RATE_LSB = 6;
  localparam int unsigned CMD_NVM_EN_BIT = 9;
  // status bits that drive the alert pin
  localparam int unsigned ST_ALL_BIT = 15;
  localparam int unsigned ST_HUM_BIT = 11;
  localparam int unsigned ST_TMP_BIT = 10;
  localparam int unsigned ST_HIGH_BIT = 4;
  // result and history values after clearing or reset
  localparam logic [15:0] TEMP_CLEARED = 16'hffff;
  localparam logic [15:0] HUM_CLEARED = 16'hffff;
  localparam logic [15:0] MIN_T_INIT = 16'hffff;
  localparam logic [15:0] MAX_T_INIT = 16'h0000;
  localparam logic [15:0] MIN_H_INIT = 16'hffff;
  localparam logic [15:0] MAX_H_INIT = 16'h0000;
  // thresholds, index 0 set high, 1 clear high, 2 set low, 3 clear low
  localparam int unsigned THR_SET_HI = 0;
  localparam int unsigned THR_CLR_HI = 1;
  localparam int unsigned THR_SET_LO = 2;
  localparam int unsigned THR_CLR_LO = 3;
  localparam logic [3:0][15:0] THR_RST =
    {16'h3869, 16'h3266, 16'hcb2d, 16'hcd33};
  localparam logic [15:0] HUM_MASK = 16'hfe00;
  localparam logic [15:0] TMP_MASK = 16'h01ff;
  // check byte
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hff;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_SOFT_RESET = 4'h1, CMD_GCALL_RESET = 4'h2,
    CMD_TRIGGER = 4'h3, CMD_AUTO_ON = 4'h4, CMD_AUTO_EXIT = 4'h5,
    CMD_CLR_STATUS = 4'h6, CMD_NVM_STATE = 4'h7
  } cmd_t;

  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00, ST_CONV = 2'b01, ST_AUTO_WAIT = 2'b10, ST_NVM = 2'b11
  } mode_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic [1:0] response;
    logic waitrequest;
  } avs_rsp_t;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic frame;
  } fe_link_t;

  // sampling period in ms, rate 0 is fastest
  function automatic logic [15:0] period_ms(input logic [2:0] r);
    case (r)
      3'h0: return 16'h0064;
      3'h1: return 16'h00fa;
      3'h2: return 16'h01f4;
      3'h3: return 16'h03e8;
      default: return 16'h07d0;
    endcase
  endfunction

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

// >>> sync2.sv
// two flip-flop synchroniser for pin and link inputs
`default_nettype none
module sync2 #(
  parameter int unsigned W = 1
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // data
  input wire logic [W-1:0] d_in,
  output wire logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sy_t;
  sy_t s, n;

  always_comb begin
    n.s1 = d_in;
    n.s2 = s.s1;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
    end else if (ce_in) begin
      s <= n;
    end
  end

  assign q_out = s.s2;
endmodule
`default_nettype wire

// >>> alert_track.sv
// hysteresis trackers for temperature and humidity alerts
`default_nettype none
module alert_track (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // control pulses
  input wire logic upd_in,
  input wire logic clr_in,
  input wire logic rst_in,
  // truncated sample and thresholds
  input wire logic [15:0] sample_in,
  input wire logic [3:0][15:0] thr_in,
  // {hum low, hum high, temp low, temp high}
  output wire logic [3:0] act_out
);
  import sensor_seq_pkg::*;
  typedef struct packed {
    logic [3:0] act;
  } trk_t;
  trk_t s, n;
  logic [3:0] trip;
  logic [3:0] rel;

  genvar q;
  generate
    for (q = 0; q < 2; q++) begin : g_qty
      localparam logic [15:0] QMASK = (q == 0) ? TMP_MASK : HUM_MASK;
      logic [15:0] v, sh, ch, sl, cl;
      logic en;
      assign v = sample_in & QMASK;
      assign sh = thr_in[THR_SET_HI] & QMASK;
      assign ch = thr_in[THR_CLR_HI] & QMASK;
      assign sl = thr_in[THR_SET_LO] & QMASK;
      assign cl = thr_in[THR_CLR_LO] & QMASK;
      // low above high switches tracking off for this quantity
      assign en = sl <= sh; // R25
      assign trip[2*q] = en && (v > sh); // R20
      assign rel[2*q] = !en || (v < ch); // R20
      assign trip[2*q+1] = en && (v < sl); // R21
      assign rel[2*q+1] = !en || (v > cl); // R21
    end
  endgenerate

  always_comb begin
    n = s;
    if (clr_in) begin
      n.act = '0; // R17
    end
    // a fresh trip wins over a clear in the same cycle
    if (upd_in) begin
      n.act = trip | (n.act & ~rel); // R17
    end
    if (rst_in) begin
      n.act = '0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
    end else if (ce_in) begin
      s <= n;
    end
  end

  assign act_out = s.act;
endmodule
`default_nettype wire

// >>> humidity_temp_measure_sequencer.sv
// measurement sequencer with alert tracking behind an Avalon-MM slave
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`default_nettype none
// Summary of operation
// R01: general call reset acts as soft reset
// R02: trigger wakes, converts temp then humidity, sleeps
// R03: host waits conversion time before reading
// R04: readout gives temp, check, humidity, check
// R05: read before conversion completes is refused
// R06: auto mode repeats conversions at set period
// R07: auto enable picks twenty period/time combinations
// R08: host keeps auto rate at most one per second
// R09: auto result cleared after readout to maximum
// R10: exit command aborts conversion, enters sleep
// R11: history starts at extreme opposite values
// R12: history updates only in auto, always readable
// R13: history restarts only on reset events
// R14: reset enters sleep or stored auto setting
// R15: host sleeps device before storage write, waits
// R16: alert pin follows status bits 15,11,10,4
// R17: alert sets on event, clears on end/clear
// R18: alert function active after every reset
// R19: alert low while reset pin held
// R20: high trip sets, high release clears alert
// R21: low trip sets, low release clears alert
// R22: host programs separated thresholds before measuring
// R23: host stays silent 77 ms after storage write
// R24: thresholds compare 7 humidity, 9 temperature bits
// R25: low trip above high trip disables tracking
// R26: comparisons and history once per conversion
module humidity_temp_measure_sequencer #(
  parameter int unsigned CYC_PER_MS = sensor_seq_pkg::CYC_PER_MS,
  parameter logic NVM_AUTO_EN = 1'b0,
  parameter logic [2:0] NVM_RATE = 3'h3,
  parameter logic [1:0] NVM_CT = 2'h0
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // register bus
  input wire sensor_seq_pkg::avs_req_t avs_req_in,
  output wire sensor_seq_pkg::avs_rsp_t avs_rsp_out,
  // converter front end
  input wire sensor_seq_pkg::fe_link_t fe_link_in,
  output wire logic fe_start_out,
  output wire logic [1:0] fe_conv_time_out,
  // pins
  input wire logic hw_reset_pin_n_in,
  output wire logic alert_out
);
  import sensor_seq_pkg::*;

  localparam logic [31:0] NVM_CYCLES =
    32'(NVM_WRITE_TIME_MS * CYC_PER_MS);

  typedef struct packed {
    avs_rsp_t rsp;
    mode_t mode;
    logic auto_on;
    logic [2:0] rate;
    logic [1:0] ct;
    logic [31:0] tick;
    logic valid;
    logic [15:0] temp;
    logic [15:0] hum;
    logic [15:0] min_t;
    logic [15:0] max_t;
    logic [15:0] min_h;
    logic [15:0] max_h;
    logic [3:0][15:0] thr;
    logic [31:0] shift;
    logic sclk_prev;
    logic frame_prev;
    logic upd;
    logic clr_stat;
    logic nvm_en;
    logic [2:0] nvm_rate;
    logic [1:0] nvm_ct;
    logic start;
    logic alert;
  } state_t;

  function automatic logic [31:0] period_cycles(input logic [2:0] r);
    return 32'(period_ms(r)) * 32'(CYC_PER_MS);
  endfunction

  // stored setting survives reset events; bus answer is left alone
  function automatic state_t apply_reset(input state_t x);
    state_t y;
    y = x;
    y.valid = 1'b0;
    y.temp = TEMP_CLEARED;
    y.hum = HUM_CLEARED;
    y.min_t = MIN_T_INIT; // R11 R13
    y.max_t = MAX_T_INIT; // R11 R13
    y.min_h = MIN_H_INIT; // R11 R13
    y.max_h = MAX_H_INIT; // R11 R13
    y.thr = THR_RST; // R18
    y.shift = '0;
    y.upd = 1'b0;
    y.clr_stat = 1'b0;
    y.alert = 1'b0;
    if (x.nvm_en) begin
      y.auto_on = 1'b1; // R14
      y.rate = x.nvm_rate;
      y.ct = x.nvm_ct;
      y.mode = ST_CONV;
      y.start = 1'b1;
      y.tick = period_cycles(x.nvm_rate);
    end else begin
      y.auto_on = 1'b0; // R14
      y.mode = ST_SLEEP;
      y.start = 1'b0;
      y.tick = '0;
    end
    return y;
  endfunction

  function automatic state_t por_state();
    state_t y;
    y = '0;
    y.rsp.waitrequest = 1'b1;
    y.nvm_en = NVM_AUTO_EN;
    y.nvm_rate = NVM_RATE;
    y.nvm_ct = NVM_CT;
    return apply_reset(y);
  endfunction

  localparam state_t S_POR = por_state();

  state_t s, n;
  logic [3:0] sy;
  fe_link_t lk;
  logic pin_ok;
  logic [3:0] trk_act;
  logic acc;
  logic done;
  logic rst_evt;
  logic thr_hit;
  logic [1:0] thr_idx;
  logic [5:0] addr;
  logic [31:0] wd;
  logic [15:0] status;
  cmd_t cmd;

  sync2 #(
    .W(4)
  ) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .d_in({hw_reset_pin_n_in, fe_link_in}),
    .q_out(sy)
  );

  assign pin_ok = sy[3];
  assign lk = fe_link_t'(sy[2:0]);
  assign addr = avs_req_in.address;
  assign wd = avs_req_in.writedata;
  assign cmd = cmd_t'(wd[CMD_CODE_LSB +: CMD_CODE_W]);
  assign acc = ce_in && (avs_req_in.read || avs_req_in.write)
    && s.rsp.waitrequest;
  assign thr_hit = (addr >= OFS_THR) && (addr <= OFS_THR_LAST);
  assign thr_idx = 2'((addr - OFS_THR) >> 2);
  assign done = (s.mode == ST_CONV) && s.frame_prev && !lk.frame;

  // only the truncated form takes part in the comparison
  alert_track u_track (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .upd_in(s.upd),
    .clr_in(s.clr_stat),
    .rst_in(rst_evt),
    .sample_in({s.hum[15:9], s.temp[15:7]}), // R24
    .thr_in(s.thr),
    .act_out(trk_act)
  );

  always_comb begin
    n = s;
    n.upd = 1'b0;
    n.clr_stat = 1'b0;
    rst_evt = 1'b0;
    status = '0;
    status[ST_TMP_BIT] = trk_act[0] | trk_act[1];
    status[ST_HUM_BIT] = trk_act[2] | trk_act[3];
    status[ST_HIGH_BIT] = trk_act[0] | trk_act[2];
    status[ST_ALL_BIT] = |trk_act;
    // link shift register, sampled on synchronised clock edges
    n.sclk_prev = lk.sclk;
    n.frame_prev = lk.frame;
    if (lk.frame && lk.sclk && !s.sclk_prev) begin
      n.shift = {s.shift[30:0], lk.sdata};
    end
    if (s.tick != '0) begin
      n.tick = s.tick - 32'h1;
    end
    case (s.mode)
      ST_CONV: begin
        if (done) begin
          n.temp = s.shift[31:16]; // R02
          n.hum = s.shift[15:0]; // R02
          n.valid = 1'b1;
          n.upd = 1'b1; // R26
          n.start = 1'b0;
          if (s.auto_on) begin
            n.mode = ST_AUTO_WAIT;
            if (n.temp < s.min_t) n.min_t = n.temp; // R12 R26
            if (n.temp > s.max_t) n.max_t = n.temp; // R12 R26
            if (n.hum < s.min_h) n.min_h = n.hum; // R12 R26
            if (n.hum > s.max_h) n.max_h = n.hum; // R12 R26
          end else begin
            n.mode = ST_SLEEP; // R02
          end
        end
      end
      ST_AUTO_WAIT: begin
        if (s.tick == '0) begin
          n.mode = ST_CONV; // R06
          n.start = 1'b1;
          n.tick = period_cycles(s.rate); // R06
        end
      end
      ST_NVM: begin
        if (s.tick == '0) begin
          n.mode = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
      end
      default: n.mode = ST_SLEEP;
    endcase
    // one wait state per access
    n.rsp.waitrequest = 1'b1;
    if (acc) begin
      n.rsp.waitrequest = 1'b0;
      n.rsp.response = RESP_OKAY;
      n.rsp.readdata = '0;
      if (avs_req_in.write) begin
        if (addr == OFS_CMD) begin
          // storage write in progress: commands are dropped
          if (s.mode != ST_NVM) begin // R15 R23
            case (cmd)
              CMD_SOFT_RESET, CMD_GCALL_RESET: begin
                rst_evt = 1'b1; // R01
                n = apply_reset(n); // R01
              end
              CMD_TRIGGER: begin
                if (s.mode == ST_SLEEP && !s.auto_on) begin
                  n.ct = wd[CMD_CT_LSB +: 2];
                  n.valid = 1'b0; // R05
                  n.mode = ST_CONV; // R02
                  n.start = 1'b1;
                end
              end
              CMD_AUTO_ON: begin
                if (wd[CMD_RATE_LSB +: 3] < 3'(RATE_COUNT)) begin // R07
                  n.auto_on = 1'b1; // R06
                  n.rate = wd[CMD_RATE_LSB +: 3]; // R07
                  n.ct = wd[CMD_CT_LSB +: 2]; // R07
                  n.valid = 1'b0;
                  n.mode = ST_CONV;
                  n.start = 1'b1;
                  n.tick = period_cycles(wd[CMD_RATE_LSB +: 3]);
                end
              end
              CMD_AUTO_EXIT: begin
                n.auto_on = 1'b0; // R10
                n.mode = ST_SLEEP; // R10
                n.start = 1'b0; // R10
                n.tick = '0;
              end
              CMD_CLR_STATUS: n.clr_stat = 1'b1; // R17
              CMD_NVM_STATE: begin
                if (s.mode == ST_SLEEP && !s.auto_on
                    && wd[CMD_RATE_LSB +: 3] < 3'(RATE_COUNT)) begin
                  n.nvm_en = wd[CMD_NVM_EN_BIT]; // R14
                  n.nvm_rate = wd[CMD_RATE_LSB +: 3];
                  n.nvm_ct = wd[CMD_CT_LSB +: 2];
                  n.mode = ST_NVM;
                  n.tick = NVM_CYCLES; // R23
                end
              end
              default: begin
              end
            endcase
          end
        end else if (thr_hit) begin
          n.thr[thr_idx] = wd[15:0];
        end else begin
          n.rsp.response = RESP_DECERR;
        end
      end else begin
        case (addr)
          OFS_STATUS: n.rsp.readdata = 32'(status);
          OFS_RES_T: begin
            if (s.valid) begin
              n.rsp.readdata = 32'({crc8(s.temp), s.temp}); // R04
            end else begin
              n.rsp.response = RESP_SLVERR; // R05
            end
          end
          OFS_RES_H: begin
            if (s.valid) begin
              n.rsp.readdata = 32'({crc8(s.hum), s.hum}); // R04
              // a result landing now must not be wiped
              if (s.auto_on && !done) begin
                n.temp = TEMP_CLEARED; // R09
                n.hum = HUM_CLEARED; // R09
              end
            end else begin
              n.rsp.response = RESP_SLVERR; // R05
            end
          end
          OFS_CFG: n.rsp.readdata = 32'({s.nvm_ct, s.nvm_rate, s.nvm_en,
            s.ct, s.rate, s.auto_on, s.mode});
          OFS_MM_T: n.rsp.readdata = {s.max_t, s.min_t}; // R12
          OFS_MM_H: n.rsp.readdata = {s.max_h, s.min_h}; // R12
          default: begin
            if (thr_hit) begin
              n.rsp.readdata = 32'(s.thr[thr_idx]);
            end else begin
              n.rsp.response = RESP_DECERR;
            end
          end
        endcase
      end
    end
    // reset pin held: all but the bus answer, the stored setting, the link edge flags and, with stored auto off, rate and ct stay at reset values
    if (!pin_ok) begin
      rst_evt = 1'b1;
      n = apply_reset(n);
    end
    n.alert = pin_ok && (status[ST_ALL_BIT] | status[ST_HUM_BIT]
      | status[ST_TMP_BIT] | status[ST_HIGH_BIT]); // R16 R19
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= S_POR;
    end else if (ce_in) begin
      s <= n;
    end
  end

  assign avs_rsp_out = s.rsp;
  assign fe_start_out = s.start;
  assign fe_conv_time_out = s.ct;
  assign alert_out = s.alert;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_cmd(cmd_t c);
    acc && avs_req_in.write && addr == OFS_CMD && cmd == c
      && s.mode != ST_NVM && pin_ok;
  endsequence
  sequence s_conv_run;
    fe_start_out && s.mode == ST_CONV;
  endsequence

  property p_gcall_reset;
    s_cmd(CMD_GCALL_RESET) |=> s.min_t == MIN_T_INIT
      && s.max_h == MAX_H_INIT && !s.valid;
  endproperty
  a_gcall_reset: assert property (p_gcall_reset) // R01
    else $error("general call reset did not reset state");

  property p_trig_start;
    s_cmd(CMD_TRIGGER) ##0 (s.mode == ST_SLEEP && !s.auto_on)
      |=> s_conv_run ##0 !s.valid;
  endproperty
  a_trig_start: assert property (p_trig_start) // R02
    else $error("trigger did not start a conversion");

  property p_trig_sleep;
    ce_in && done && !s.auto_on && pin_ok && !acc
      |=> s.mode == ST_SLEEP && !fe_start_out && s.valid;
  endproperty
  a_trig_sleep: assert property (p_trig_sleep) // R02
    else $error("triggered conversion did not return to sleep");

  property p_res_t_data;
    acc && avs_req_in.read && addr == OFS_RES_T && s.valid
      |=> avs_rsp_out.readdata[15:0] == $past(s.temp)
      && avs_rsp_out.readdata[23:16] == crc8($past(s.temp))
      && !avs_rsp_out.waitrequest;
  endproperty
  a_res_t_data: assert property (p_res_t_data) // R04
    else $error("temperature readout wrong");

  property p_not_ready;
    acc && avs_req_in.read && !s.valid
      && (addr == OFS_RES_T || addr == OFS_RES_H)
      |=> avs_rsp_out.response == RESP_SLVERR
      && avs_rsp_out.readdata == '0;
  endproperty
  a_not_ready: assert property (p_not_ready) // R05
    else $error("read before completion was not refused");

  property p_auto_repeat;
    ce_in && s.mode == ST_AUTO_WAIT && s.tick == '0 && !acc && pin_ok
      |=> s_conv_run ##0 s.tick == period_cycles(s.rate);
  endproperty
  a_auto_repeat: assert property (p_auto_repeat) // R06
    else $error("auto mode did not start the next conversion");

  property p_read_clear;
    acc && avs_req_in.read && addr == OFS_RES_H && s.valid
      && s.auto_on && !done && pin_ok
      |=> s.temp == TEMP_CLEARED && s.hum == HUM_CLEARED;
  endproperty
  a_read_clear: assert property (p_read_clear) // R09
    else $error("auto result not cleared after readout");

  property p_exit;
    s_cmd(CMD_AUTO_EXIT) |=> s.mode == ST_SLEEP && !fe_start_out
      && !s.auto_on;
  endproperty
  a_exit: assert property (p_exit) // R10
    else $error("exit did not abort into sleep");

  property p_hist_hold;
    ce_in && !s.auto_on && pin_ok && !acc
      |=> $stable(s.min_t) && $stable(s.max_t) && $stable(s.max_h);
  endproperty
  a_hist_hold: assert property (p_hist_hold) // R12
    else $error("history changed outside auto mode");

  property p_pin_low;
    ce_in && !pin_ok |=> !alert_out ##0 s.min_h == MIN_H_INIT;
  endproperty
  a_pin_low: assert property (p_pin_low) // R19
    else $error("alert high while reset pin held");

  property p_alert_map;
    ce_in && pin_ok |=> alert_out == $past(|trk_act);
  endproperty
  a_alert_map: assert property (p_alert_map) // R16
    else $error("alert pin does not follow status bits");
endmodule
`default_nettype wire

// >>> fe_model.sv
// behavioural converter front end answering conversion requests
`default_nettype none
module fe_model (
  // request
  input wire logic start_in,
  input wire logic slow_in,
  input wire logic [31:0] word_in,
  // link
  output var sensor_seq_pkg::fe_link_t link_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import sensor_seq_pkg::*;
  initial begin
    link_out = '0;
    forever begin
      @(posedge start_in);
      #(slow_in ? 3000 : 333);
      link_out.frame = 1'b1;
      for (int i = 31; i >= 0; i--) begin
        link_out.sdata = word_in[i];
        #40 link_out.sclk = 1'b1;
        #40 link_out.sclk = 1'b0;
      end
      #40 link_out.frame = 1'b0;
      // released line must not keep the last bit
      link_out.sdata = ~link_out.sdata;
    end
  end
endmodule
`default_nettype wire

// >>> humidity_temp_measure_sequencer_tb.sv
// self-checking bench for the measurement sequencer
`default_nettype none
module humidity_temp_measure_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sensor_seq_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic pin_n = 1'b1;
  logic slow = 1'b0;
  logic start, alert;
  logic [1:0] ct, cts, r;
  logic [31:0] fe_word = '0;
  logic [31:0] q;
  logic [15:0] t1, h1, t2, h2;
  logic [15:0] thr_def [4] = '{16'hcd33, 16'hcb2d, 16'h3266, 16'h3869};
  avs_req_t req = '0;
  avs_rsp_t rsp;
  fe_link_t link;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  initial forever #5 clk_in = ~clk_in;
  humidity_temp_measure_sequencer #(.CYC_PER_MS(10))
    humidity_temp_measure_sequencer_inst (.clk_in(clk_in),
    .resetn_in(resetn_in), .ce_in(1'b1), .avs_req_in(req),
    .avs_rsp_out(rsp), .fe_link_in(link), .fe_start_out(start),
    .fe_conv_time_out(ct), .hw_reset_pin_n_in(pin_n), .alert_out(alert));
  fe_model fe_model_inst (.start_in(start), .slow_in(slow),
    .word_in(fe_word), .link_out(link));
  function automatic logic [7:0] ck(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) c = (c[7] ^ d[i]) ? (c << 1) ^ 8'h31 : c << 1;
    return c;
  endfunction
  task automatic chk(input string n, input logic [33:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    req <= '{read: !w, write: w, address: a, writedata: d};
    do @(posedge clk_in); while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    r = rsp.response;
    req <= '0;
    @(posedge clk_in);
  endtask
  task automatic rc(input string n, input logic [5:0] a, input logic [31:0] e,
      input logic [1:0] er);
    bus(1'b0, a, 32'h0);
    chk(n, {er, e}, {r, q});
  endtask
  task automatic res(input logic [15:0] t, h);
    rc("res_t", OFS_RES_T, {8'h0, ck(t), t}, RESP_OKAY);
    rc("res_h", OFS_RES_H, {8'h0, ck(h), h}, RESP_OKAY);
  endtask
  task automatic conv(input logic [15:0] t, h, input logic [31:0] cmd,
      input logic probe);
    fe_word = {t, h};
    if (cmd != 0) bus(1'b1, OFS_CMD, cmd);
    wait (start === 1'b1);
    cts = ct;
    @(posedge clk_in);
    if (probe) rc("early", OFS_RES_T, 32'h0, RESP_SLVERR);
    wait (start === 1'b0);
    repeat (4) @(posedge clk_in);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 40000) begin
      num_errors++;
      end_sim;
    end
  end
  initial begin
    void'($urandom(32'h8bd7d04e));
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    for (int i = 0; i < 4; i++)
      rc("thr", OFS_THR + 6'(4 * i), {16'h0, thr_def[i]}, RESP_OKAY);
    rc("mm_t", OFS_MM_T, 32'h0000ffff, RESP_OKAY);
    bus(1'b0, 6'h2c, 32'h0);
    chk("unmapped", {RESP_DECERR, 32'h0}, {r, q});
    bus(1'b1, OFS_THR, 32'h1234);
    rc("thr_wr", OFS_THR, 32'h1234, RESP_OKAY);
    rc("res_t", OFS_RES_T, 32'h0, RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      t1 = 16'($urandom);
      h1 = 16'($urandom);
      slow = (i == 3);
      conv(t1, h1, 32'(i << CMD_CT_LSB) | 32'h3, 1'b1);
      chk("ct", 34'(i), 34'(cts));
      res(t1, h1);
    end
    rc("mm_t", OFS_MM_T, 32'h0000ffff, RESP_OKAY);
    $display("test trigger done");
    bus(1'b1, OFS_CMD, 32'h1);
    rc("thr", OFS_THR, {16'h0, thr_def[0]}, RESP_OKAY);
    for (int i = 0; i < 4; i++)
      bus(1'b1, OFS_THR + 6'(4 * i), {16'h0, thr_def[i]});
    conv(16'hffff, 16'h8000, 32'h3, 1'b0);
    rc("status", OFS_STATUS, 32'h8410, RESP_OKAY);
    chk("alert", 34'h1, 34'(alert));
    conv(16'h8000, 16'h8000, 32'h3, 1'b0);
    chk("alert", 34'h0, 34'(alert));
    conv(16'h0000, 16'h8000, 32'h3, 1'b0);
    rc("status", OFS_STATUS, 32'h8400, RESP_OKAY);
    chk("alert", 34'h1, 34'(alert));
    bus(1'b1, OFS_CMD, 32'h6);
    repeat (2) @(posedge clk_in);
    chk("alert", 34'h0, 34'(alert));
    // set-low temp bits above set-high: temp tracking off
    bus(1'b1, OFS_THR + 6'h8, 32'h33ff);
    conv(16'hffff, 16'h8000, 32'h3, 1'b0);
    rc("status", OFS_STATUS, 32'h0, RESP_OKAY);
    chk("alert", 34'h0, 34'(alert));
    $display("test alert done");
    {t1, h1, t2, h2} = {$urandom, $urandom};
    conv(t1, h1, 32'hc4, 1'b0);
    res(t1, h1);
    res(16'hffff, 16'hffff);
    conv(t2, h2, 32'h0, 1'b0);
    rc("mm_t", OFS_MM_T, {t1 > t2 ? t1 : t2, t1 < t2 ? t1 : t2},
      RESP_OKAY);
    rc("mm_h", OFS_MM_H, {h1 > h2 ? h1 : h2, h1 < h2 ? h1 : h2},
      RESP_OKAY);
    wait (start === 1'b1);
    @(posedge clk_in);
    bus(1'b1, OFS_CMD, 32'h5);
    chk("start", 34'h0, 34'(start));
    bus(1'b0, OFS_CFG, 32'h0);
    chk("mode", 34'h0, 34'(q[2:0]));
    rc("mm_t", OFS_MM_T, {t1 > t2 ? t1 : t2, t1 < t2 ? t1 : t2},
      RESP_OKAY);
    for (int i = 0; i < 20; i++) begin
      bus(1'b1, OFS_CMD, 32'((i % 5) << 6 | (i / 5) << 4) | 32'h4);
      bus(1'b0, OFS_CFG, 32'h0);
      chk("cfg", 34'(5 | (i % 5) << 3 | (i / 5) << 6), 34'(q[7:0]));
    end
    bus(1'b1, OFS_CMD, 32'h2);
    rc("mm_t", OFS_MM_T, 32'h0000ffff, RESP_OKAY);
    wait (link.frame === 1'b0);
    // let the synchronised frame fall pass before a new trigger
    repeat (4) @(posedge clk_in);
    $display("test auto done");
    conv(16'hffff, 16'h8000, 32'h3, 1'b0);
    pin_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk("alert", 34'h0, 34'(alert));
    pin_n <= 1'b1;
    repeat (4) @(posedge clk_in);
    conv(16'hffff, 16'h8000, 32'h3, 1'b0);
    chk("alert", 34'h1, 34'(alert));
    $display("test pin done");
    bus(1'b1, OFS_CMD, 32'h2d7);
    repeat (NVM_WRITE_TIME_MS * 10) @(posedge clk_in);
    bus(1'b0, OFS_CFG, 32'h0);
    chk("nvm", 34'h5c, 34'({q[13:8], q[1:0]}));
    bus(1'b1, OFS_CMD, 32'h1);
    bus(1'b0, OFS_CFG, 32'h0);
    chk("boot", 34'h175d, 34'(q[13:0]));
    $display("test storage done");
    end_sim;
  end
endmodule
`default_nettype wire
